/* inc/udbc_pkg.sv */
// Constants, state types and register layout of the serial data/baud/control block.
// Assumes a single pclk domain and an APB master with 32-bit data.
package udbc_pkg;

    // Register byte offsets
    localparam logic [7:0] UDBC_OFF_FLAGS   = 8'h00;
    localparam logic [7:0] UDBC_OFF_DATA    = 8'h04;
    localparam logic [7:0] UDBC_OFF_BAUD    = 8'h08;
    localparam logic [7:0] UDBC_OFF_CTL     = 8'h0C;
    localparam logic [7:0] UDBC_OFF_AUX     = 8'h14;
    localparam logic [7:0] UDBC_OFF_EV_STAT = 8'h18;
    localparam logic [7:0] UDBC_OFF_EV_MASK = 8'h1C;

    // Status flag positions
    localparam int UDBC_FLG_PARITY  = 0;
    localparam int UDBC_FLG_FRAME   = 1;
    localparam int UDBC_FLG_NOISE   = 2;
    localparam int UDBC_FLG_OVERRUN = 3;
    localparam int UDBC_FLG_IDLE    = 4;
    localparam int UDBC_FLG_RX_FULL = 5;
    localparam int UDBC_FLG_TX_DONE = 6;
    localparam int UDBC_FLG_TX_FREE = 7;

    // control_one positions
    localparam int UDBC_CTL_UNIT_EN  = 13;
    localparam int UDBC_CTL_NINE     = 12;
    localparam int UDBC_CTL_WAKE_ADR = 11;
    localparam int UDBC_CTL_PAR_EN   = 10;
    localparam int UDBC_CTL_PAR_ODD  = 9;
    localparam int UDBC_CTL_PAR_IRQ  = 8;
    localparam int UDBC_CTL_TX_EN    = 3;
    localparam int UDBC_CTL_RX_EN    = 2;
    localparam int UDBC_CTL_SILENT   = 1;

    // aux_control and event positions
    localparam int UDBC_AUX_ERR_IRQ = 0;
    localparam int UDBC_AUX_MULTBUF = 1;
    localparam int UDBC_EV_PARITY   = 0;
    localparam int UDBC_EV_FRAME    = 1;
    localparam int UDBC_EV_RX_FULL  = 2;
    localparam int UDBC_EV_TX_DONE  = 3;

    // Reset values
    localparam logic [7:0]  UDBC_FLAGS_RST = 8'hC0;
    localparam logic [15:0] UDBC_BAUD_RST  = 16'h0000;

    // Oversampling: 16 ticks a bit, majority of ticks 7..9
    localparam logic [16:0] UDBC_ACC_STEP   = 17'h00010;
    localparam logic [15:0] UDBC_DIV_MIN    = 16'h0010;
    localparam logic [3:0]  UDBC_TICK_LAST  = 4'hF;
    localparam logic [3:0]  UDBC_SMP_FIRST  = 4'h7;
    localparam logic [3:0]  UDBC_SMP_LAST   = 4'h9;
    localparam logic [3:0]  UDBC_LAST_BIT_8 = 4'h7;
    localparam logic [3:0]  UDBC_LAST_BIT_9 = 4'h8;
    localparam logic [7:0]  UDBC_IDLE_8     = 8'hA0;
    localparam logic [7:0]  UDBC_IDLE_9     = 8'hB0;

    typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} udbc_tx_st_t;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} udbc_rx_st_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        irq;
        logic [15:0] baud;
        logic [13:0] ctl;
        logic [1:0]  aux;
        logic [7:0]  flags;
        logic [6:0]  armed;
        logic [3:0]  ev_stat;
        logic [3:0]  ev_mask;
        logic [8:0]  rx_hold;
        logic [8:0]  tx_hold;
        logic [16:0] acc;
        udbc_tx_st_t tx_st;
        logic [3:0]  tx_tick;
        logic [3:0]  tx_bit;
        logic [8:0]  tx_shift;
        logic        tx_par;
        logic        tx_par_en;
        logic        tx_nine;
        logic        tx_low;
        udbc_rx_st_t rx_st;
        logic [3:0]  rx_tick;
        logic [3:0]  rx_bit;
        logic [8:0]  rx_shift;
        logic [2:0]  rx_smp;
        logic        rx_noise;
        logic        rx_par_en;
        logic        rx_odd;
        logic        rx_nine;
        logic [7:0]  idle_cnt;
        logic        idle_arm;
    } udbc_state_t;

    localparam udbc_state_t UDBC_STATE_RST = udbc_state_t'(0);

endpackage

/* rtl/udbc_core.sv */
// Serial transceiver with APB registers: flags, data window, baud divider, control.
// Assumes APB master on pclk; rxd already synchronous to pclk.
// What this block does
// - Set frame flag on bad stop; noise sets the noise flag
// - Flag read then data read clears frame flag
// - Frame interrupt only with multibuffer and enable
// - Set parity flag on received parity mismatch
// - Flag read then data read clears parity
// - Parity flag raises interrupt when enabled
// - Nine-bit window: read receive, write transmit
// - Divider integer part from bits 15..4
// - Divider fraction from bits 3..0
// - Disable takes effect after current byte
// - Word length bit selects 9 or 8 bits
// - Silent mode wakes by address or idle
// - Parity enable inserts and checks parity bit
// - Parity enable change applies next byte
// - Parity select: zero even, one odd
// - Receiver enable starts start-bit search
`timescale 1ns/1ps
module udbc_core
    import udbc_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Serial line
    input  wire logic        rxd,
    output logic             txd,
    // Interrupt
    output logic             irq
);

    udbc_state_t s_r;
    udbc_state_t s_nxt;
    logic        run;
    logic        tick;
    logic [16:0] acc_sum;
    logic        setup;
    logic        access;
    logic        mapped;
    logic [31:0] rd_mux;
    logic        tx_bitval;
    logic [3:0]  tx_last;
    logic [3:0]  rx_last;
    logic        maj;
    logic        noisy;
    logic        rx_deliver;
    logic        rx_bad_stop;
    logic        rx_perr;
    logic        accept;
    logic [8:0]  rx_data;
    logic [7:0]  idle_lim;

    assign setup   = psel & ~penable;
    assign access  = psel & penable;
    assign pready  = 1'b1;
    assign pslverr = access & ~mapped;
    assign prdata  = s_r.prdata;
    assign txd     = ~s_r.tx_low;
    assign irq     = s_r.irq;

    always_comb begin
        mapped = 1'b1;
        rd_mux = 32'h0000_0000;
        case (paddr)
            UDBC_OFF_FLAGS:   rd_mux = {24'h000000, s_r.flags};
            UDBC_OFF_DATA:    rd_mux = {23'h000000, s_r.rx_hold};
            UDBC_OFF_BAUD:    rd_mux = {16'h0000, s_r.baud};
            UDBC_OFF_CTL:     rd_mux = {18'h00000, s_r.ctl};
            UDBC_OFF_AUX:     rd_mux = {30'h00000000, s_r.aux};
            UDBC_OFF_EV_STAT: rd_mux = {28'h0000000, s_r.ev_stat};
            UDBC_OFF_EV_MASK: rd_mux = {28'h0000000, s_r.ev_mask};
            default:          mapped = 1'b0;
        endcase
    end

    always_comb begin
        s_nxt       = s_r;
        rx_deliver  = 1'b0;
        rx_bad_stop = 1'b0;
        accept      = 1'b0;
        maj = (s_r.rx_smp[0] & s_r.rx_smp[1]) | (s_r.rx_smp[1] & s_r.rx_smp[2])
            | (s_r.rx_smp[0] & s_r.rx_smp[2]);
        noisy   = ~(&s_r.rx_smp) & (|s_r.rx_smp);
        rx_data = s_r.rx_nine ? s_r.rx_shift : {1'b0, s_r.rx_shift[8:1]};
        rx_perr = s_r.rx_par_en & ((^rx_data) ^ s_r.rx_odd);
        tx_last = s_r.tx_nine ? UDBC_LAST_BIT_9 : UDBC_LAST_BIT_8;
        rx_last = s_r.rx_nine ? UDBC_LAST_BIT_9 : UDBC_LAST_BIT_8;
        idle_lim = s_r.ctl[UDBC_CTL_NINE] ? UDBC_IDLE_9 : UDBC_IDLE_8;
        tx_bitval = 1'b1;

        // Fractional divider in sixteenths of a clock; below 1.0 it stays idle
        run = s_r.ctl[UDBC_CTL_UNIT_EN] | (s_r.tx_st != TX_IDLE)
            | (s_r.rx_st != RX_IDLE);
        acc_sum = s_r.acc + UDBC_ACC_STEP;
        tick = run && (s_r.baud >= UDBC_DIV_MIN) && (acc_sum >= {1'b0, s_r.baud});
        if (!run || s_r.baud < UDBC_DIV_MIN) begin
            s_nxt.acc = 17'h00000;
        end else if (tick) begin
            s_nxt.acc = acc_sum - {1'b0, s_r.baud};
        end else begin
            s_nxt.acc = acc_sum;
        end

        // Bus side first, so hardware sets below win over clears
        if (setup && !pwrite) begin
            s_nxt.prdata = rd_mux;
        end
        if (access && !pwrite) begin
            case (paddr)
                UDBC_OFF_FLAGS: s_nxt.armed = s_r.prdata[6:0];
                UDBC_OFF_DATA: begin
                    // Only flags 4..0 seen by the flag read are cleared; receive-full always clears
                    s_nxt.flags[4:0] = s_r.flags[4:0] & ~s_r.armed[4:0];
                    s_nxt.flags[UDBC_FLG_RX_FULL] = 1'b0;
                    s_nxt.armed = 7'h00;
                end
                UDBC_OFF_EV_STAT: s_nxt.ev_stat = s_r.ev_stat & ~s_r.prdata[3:0];
                default: ;
            endcase
        end
        if (access && pwrite) begin
            case (paddr)
                UDBC_OFF_FLAGS: begin
                    if (!pwdata[UDBC_FLG_RX_FULL]) s_nxt.flags[UDBC_FLG_RX_FULL] = 1'b0;
                    if (!pwdata[UDBC_FLG_TX_DONE]) s_nxt.flags[UDBC_FLG_TX_DONE] = 1'b0;
                end
                UDBC_OFF_DATA: begin
                    s_nxt.tx_hold = pwdata[8:0];
                    s_nxt.flags[UDBC_FLG_TX_FREE] = 1'b0;
                    if (s_r.armed[UDBC_FLG_TX_DONE]) s_nxt.flags[UDBC_FLG_TX_DONE] = 1'b0;
                    s_nxt.armed = 7'h00;
                end
                UDBC_OFF_BAUD: s_nxt.baud = pwdata[15:0];
                UDBC_OFF_CTL: begin
                    s_nxt.ctl = pwdata[13:0];
                    // Address-mark wakeup: silent bit locked while data waits
                    if (s_r.ctl[UDBC_CTL_WAKE_ADR] && s_r.flags[UDBC_FLG_RX_FULL])
                        s_nxt.ctl[UDBC_CTL_SILENT] = s_r.ctl[UDBC_CTL_SILENT];
                end
                UDBC_OFF_AUX:     s_nxt.aux = pwdata[1:0];
                UDBC_OFF_EV_MASK: s_nxt.ev_mask = pwdata[3:0];
                default: ;
            endcase
        end

        // Transmitter
        case (s_r.tx_st)
            TX_IDLE: begin
                s_nxt.tx_low = 1'b0;
                if (s_r.ctl[UDBC_CTL_UNIT_EN] && s_r.ctl[UDBC_CTL_TX_EN]
                    && !s_r.flags[UDBC_FLG_TX_FREE]
                    && !(access && pwrite && paddr == UDBC_OFF_DATA)) begin
                    s_nxt.tx_shift  = s_r.tx_hold;
                    s_nxt.flags[UDBC_FLG_TX_FREE] = 1'b1;
                    s_nxt.tx_nine   = s_r.ctl[UDBC_CTL_NINE];
                    s_nxt.tx_par_en = s_r.ctl[UDBC_CTL_PAR_EN];
                    s_nxt.tx_par    = s_r.ctl[UDBC_CTL_PAR_ODD];
                    s_nxt.tx_tick   = 4'h0;
                    s_nxt.tx_bit    = 4'h0;
                    s_nxt.tx_low    = 1'b1;
                    s_nxt.tx_st     = TX_START;
                end
            end
            TX_START, TX_DATA: begin
                if (tick) begin
                    s_nxt.tx_tick = s_r.tx_tick + 4'h1;
                    if (s_r.tx_tick == UDBC_TICK_LAST) begin
                        if (s_r.tx_st == TX_DATA && s_r.tx_bit == tx_last) begin
                            s_nxt.tx_st  = TX_STOP;
                            s_nxt.tx_low = 1'b0;
                        end else begin
                            if (s_r.tx_st == TX_DATA) begin
                                s_nxt.tx_bit   = s_r.tx_bit + 4'h1;
                                s_nxt.tx_shift = {1'b0, s_r.tx_shift[8:1]};
                            end
                            tx_bitval = s_nxt.tx_shift[0];
                            if (s_r.tx_par_en && s_nxt.tx_bit == tx_last) begin
                                tx_bitval = s_r.tx_par;
                            end else begin
                                s_nxt.tx_par = s_r.tx_par ^ s_nxt.tx_shift[0];
                            end
                            s_nxt.tx_low = ~tx_bitval;
                            s_nxt.tx_st  = TX_DATA;
                        end
                    end
                end
            end
            TX_STOP: begin
                if (tick) begin
                    s_nxt.tx_tick = s_r.tx_tick + 4'h1;
                    if (s_r.tx_tick == UDBC_TICK_LAST) begin
                        s_nxt.tx_st = TX_IDLE;
                        if (s_nxt.flags[UDBC_FLG_TX_FREE]) begin
                            s_nxt.flags[UDBC_FLG_TX_DONE] = 1'b1;
                            s_nxt.ev_stat[UDBC_EV_TX_DONE] = 1'b1;
                        end
                    end
                end
            end
            default: s_nxt.tx_st = TX_IDLE;
        endcase

        // Receiver
        case (s_r.rx_st)
            RX_IDLE: begin
                if (s_r.ctl[UDBC_CTL_UNIT_EN] && s_r.ctl[UDBC_CTL_RX_EN]) begin
                    if (!rxd) begin
                        s_nxt.rx_st     = RX_START;
                        s_nxt.rx_tick   = 4'h0;
                        s_nxt.rx_bit    = 4'h0;
                        s_nxt.rx_noise  = 1'b0;
                        s_nxt.rx_nine   = s_r.ctl[UDBC_CTL_NINE];
                        s_nxt.rx_par_en = s_r.ctl[UDBC_CTL_PAR_EN];
                        s_nxt.rx_odd    = s_r.ctl[UDBC_CTL_PAR_ODD];
                        s_nxt.idle_cnt  = 8'h00;
                    end else if (tick && s_r.idle_cnt < idle_lim) begin
                        s_nxt.idle_cnt = s_r.idle_cnt + 8'h01;
                        if (s_nxt.idle_cnt == idle_lim) begin
                            if (s_r.idle_arm) begin
                                s_nxt.flags[UDBC_FLG_IDLE] = 1'b1;
                                s_nxt.idle_arm = 1'b0;
                            end
                            if (!s_r.ctl[UDBC_CTL_WAKE_ADR])
                                s_nxt.ctl[UDBC_CTL_SILENT] = 1'b0;
                        end
                    end
                end
            end
            RX_START, RX_DATA, RX_STOP: begin
                if (tick) begin
                    s_nxt.rx_tick = s_r.rx_tick + 4'h1;
                    if (s_r.rx_tick >= UDBC_SMP_FIRST && s_r.rx_tick <= UDBC_SMP_LAST)
                        s_nxt.rx_smp = {s_r.rx_smp[1:0], rxd};
                    if (s_r.rx_tick == UDBC_TICK_LAST) begin
                        s_nxt.rx_noise = s_r.rx_noise | noisy;
                        case (s_r.rx_st)
                            RX_START: s_nxt.rx_st = maj ? RX_IDLE : RX_DATA;
                            RX_DATA: begin
                                s_nxt.rx_shift = {maj, s_r.rx_shift[8:1]};
                                s_nxt.rx_bit   = s_r.rx_bit + 4'h1;
                                if (s_r.rx_bit == rx_last) s_nxt.rx_st = RX_STOP;
                            end
                            default: begin
                                s_nxt.rx_st = RX_IDLE;
                                rx_deliver  = 1'b1;
                                rx_bad_stop = ~maj;
                            end
                        endcase
                    end
                end
            end
            default: s_nxt.rx_st = RX_IDLE;
        endcase

        if (rx_deliver) begin
            accept = ~s_r.ctl[UDBC_CTL_SILENT];
            if (s_r.ctl[UDBC_CTL_SILENT] && s_r.ctl[UDBC_CTL_WAKE_ADR]
                && s_r.rx_shift[8]) begin
                s_nxt.ctl[UDBC_CTL_SILENT] = 1'b0;
                accept = 1'b1;
            end
        end
        if (accept) begin
            if (s_nxt.flags[UDBC_FLG_RX_FULL]) begin
                // Holding word kept; the new frame is dropped
                s_nxt.flags[UDBC_FLG_OVERRUN] = 1'b1;
            end else begin
                s_nxt.rx_hold  = rx_data;
                s_nxt.idle_arm = 1'b1;
                s_nxt.flags[UDBC_FLG_RX_FULL] = 1'b1;
                s_nxt.ev_stat[UDBC_EV_RX_FULL] = 1'b1;
                if (s_r.rx_noise | noisy) s_nxt.flags[UDBC_FLG_NOISE] = 1'b1;
                if (rx_bad_stop) begin
                    s_nxt.flags[UDBC_FLG_FRAME] = 1'b1;
                    if (s_r.aux[UDBC_AUX_ERR_IRQ] && s_r.aux[UDBC_AUX_MULTBUF])
                        s_nxt.ev_stat[UDBC_EV_FRAME] = 1'b1;
                end
                if (rx_perr) begin
                    s_nxt.flags[UDBC_FLG_PARITY] = 1'b1;
                    if (s_r.ctl[UDBC_CTL_PAR_IRQ])
                        s_nxt.ev_stat[UDBC_EV_PARITY] = 1'b1;
                end
            end
        end

        s_nxt.irq = |(s_nxt.ev_stat & s_nxt.ev_mask);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r       <= UDBC_STATE_RST;
            s_r.flags <= UDBC_FLAGS_RST;
            s_r.baud  <= UDBC_BAUD_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Checking helpers: cycles between baud ticks
    logic [15:0] gap_r;
    logic        gap_ok_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_r    <= 16'h0000;
            gap_ok_r <= 1'b0;
        end else begin
            gap_r    <= tick ? 16'h0001 : gap_r + 16'h0001;
            gap_ok_r <= tick ? 1'b1 : (gap_ok_r & run & (s_nxt.baud == s_r.baud));
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence flag_read_frame;
        access && !pwrite && paddr == UDBC_OFF_FLAGS && s_r.prdata[UDBC_FLG_FRAME];
    endsequence
    sequence data_read_quiet;
        access && !pwrite && paddr == UDBC_OFF_DATA && !accept;
    endsequence

    a_frame_set: assert property (
        (accept && rx_bad_stop && !s_r.flags[UDBC_FLG_RX_FULL])
        |=> s_r.flags[UDBC_FLG_FRAME])
        else $error("frame flag not set on bad stop");
    a_frame_clear: assert property (
        flag_read_frame ##3 data_read_quiet |=> !s_r.flags[UDBC_FLG_FRAME])
        else $error("frame flag survived flag read then data read");
    a_frame_irq_gate: assert property (
        $rose(s_r.ev_stat[UDBC_EV_FRAME])
        |-> $past(s_r.aux[UDBC_AUX_ERR_IRQ] && s_r.aux[UDBC_AUX_MULTBUF]))
        else $error("frame event without enable and multibuffer");
    a_parity_set: assert property (
        (accept && rx_perr && !s_r.flags[UDBC_FLG_RX_FULL])
        |=> s_r.flags[UDBC_FLG_PARITY] && s_r.flags[UDBC_FLG_RX_FULL])
        else $error("parity flag not set on mismatch");
    a_parity_irq: assert property (
        ($rose(s_r.flags[UDBC_FLG_PARITY]) && $past(s_r.ctl[UDBC_CTL_PAR_IRQ]))
        |-> s_r.ev_stat[UDBC_EV_PARITY] ##1 (s_r.irq || !s_r.ev_mask[UDBC_EV_PARITY]))
        else $error("parity event or interrupt missing");
    a_data_window: assert property (
        (setup && !pwrite && paddr == UDBC_OFF_DATA)
        |=> prdata == {23'h000000, $past(s_r.rx_hold)})
        else $error("data window read mismatch");
    a_baud_period: assert property (
        (tick && gap_ok_r && s_r.baud[3:0] == 4'h0) |-> gap_r == {4'h0, s_r.baud[15:4]})
        else $error("baud tick spacing wrong");
    a_disable_finish: assert property (
        (s_r.tx_st == TX_DATA && !s_r.ctl[UDBC_CTL_UNIT_EN])
        |=> s_r.tx_st == TX_DATA || s_r.tx_st == TX_STOP)
        else $error("frame cut short by disable");
    a_word_length: assert property (
        (s_r.tx_st == TX_DATA ##1 s_r.tx_st == TX_STOP)
        |-> $past(s_r.tx_bit) == ($past(s_r.tx_nine) ? UDBC_LAST_BIT_9 : UDBC_LAST_BIT_8))
        else $error("wrong number of data bits");
    a_parity_latched: assert property (
        (s_r.tx_st != TX_IDLE && $past(s_r.tx_st) != TX_IDLE) |-> $stable(s_r.tx_par_en))
        else $error("parity enable changed mid frame");
    a_wake_addr: assert property (
        (rx_deliver && s_r.ctl[UDBC_CTL_SILENT] && s_r.ctl[UDBC_CTL_WAKE_ADR]
         && s_r.rx_shift[8]) |=> !s_r.ctl[UDBC_CTL_SILENT])
        else $error("address mark did not wake receiver");

endmodule

/* test/tb_top.sv */
// Self-checking bench: APB register access plus a serial peer on the line.
// Assumes baud value 0x18, so one bit is 24 pclk cycles.
`timescale 1ns/1ps
module tb_top
    import udbc_pkg::*;
;
    localparam logic [31:0] C_RUN = 32'h0000200C, C_PAR = 32'h00000400, C_ODD = 32'h00000200;
    localparam logic [31:0] C_PIRQ = 32'h00000100, C_NINE = 32'h00001000, C_RE = 32'h00000004;
    localparam logic [31:0] C_WAKE = 32'h00000800, C_SIL = 32'h00000002;

    logic        pclk = 1'b0;
    logic        presetn, psel, penable, pwrite, pready, pslverr, rxd, txd, irq, serr, s;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, r;
    logic [8:0]  d;
    int          failures, n_tests, cycles;

    always #50 pclk = ~pclk;

    udbc_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rxd(rxd), .txd(txd), .irq(irq));
    udbc_peer #(.BIT(24)) peer (.pclk(pclk), .rxd(rxd), .txd(txd));

    task automatic chk(input logic [31:0] got, input logic [31:0] m, input logic [31:0] e);
        n_tests++;
        if ((got & m) !== e) begin
            failures++;
            $display("[ERR] %0t got %h expected %h", $time, got & m, e);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(r, m, e);
    endtask

    task automatic final_report();
        $display("Checks %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Whole run needs about 2700 cycles
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            final_report();
        end
    end

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {failures, n_tests, cycles} = '0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rd(UDBC_OFF_BAUD, 32'hFFFFFFFF, 32'h0);
        rd(UDBC_OFF_FLAGS, 32'hFFFFFFFF, 32'hC0);
        rd(8'h20, 32'hFFFFFFFF, 32'h0);
        chk({31'h0, serr}, 32'h1, 32'h1);
        apb(1'b1, UDBC_OFF_BAUD, 32'hFFFF0018);
        rd(UDBC_OFF_BAUD, 32'hFFFFFFFF, 32'h18);
        apb(1'b1, UDBC_OFF_EV_MASK, 32'h3);
        // Control rewritten mid-byte: the byte in flight keeps its format
        for (int k = 0; k < 2; k++) begin
            fork
                peer.recv(d, s, 8);
                begin
                    apb(1'b1, UDBC_OFF_CTL, C_RUN | C_PAR | (k[0] ? C_ODD : 32'h0));
                    apb(1'b1, UDBC_OFF_DATA, 32'h34);
                    // Previous stop bit may still run; rewrite only once the start bit is out
                    wait (txd === 1'b0);
                    apb(1'b1, UDBC_OFF_CTL, k[0] ? 32'h0 : C_RUN);
                end
            join
            chk({23'h0, d}, 32'hFF, {24'h0, ^(7'h34) ^ k[0], 7'h34});
            chk({31'h0, s}, 32'h1, 32'h1);
        end
        apb(1'b1, UDBC_OFF_CTL, C_RUN | C_PAR | C_PIRQ);
        peer.send(9'h034, 8, 1'b1);
        chk({31'h0, irq}, 32'h1, 32'h1);
        rd(UDBC_OFF_FLAGS, 32'h23, 32'h21);
        rd(UDBC_OFF_DATA, 32'h7F, 32'h34);
        rd(UDBC_OFF_FLAGS, 32'h1, 32'h0);
        rd(UDBC_OFF_EV_STAT, 32'h1, 32'h1);
        apb(1'b1, UDBC_OFF_CTL, C_RUN);
        chk({31'h0, irq}, 32'h1, 32'h0);
        peer.send(9'h05A, 8, 1'b0);
        chk({31'h0, irq}, 32'h1, 32'h0);
        rd(UDBC_OFF_FLAGS, 32'h2, 32'h2);
        apb(1'b0, UDBC_OFF_DATA, 32'h0);
        rd(UDBC_OFF_FLAGS, 32'h2, 32'h0);
        apb(1'b1, UDBC_OFF_AUX, 32'h3);
        peer.send(9'h05A, 8, 1'b0);
        chk({31'h0, irq}, 32'h1, 32'h1);
        rd(UDBC_OFF_FLAGS, 32'h2, 32'h2);
        apb(1'b0, UDBC_OFF_DATA, 32'h0);
        apb(1'b1, UDBC_OFF_CTL, C_RUN | C_NINE);
        peer.send(9'h1A5, 9, 1'b1);
        rd(UDBC_OFF_FLAGS, 32'h20, 32'h20);
        rd(UDBC_OFF_DATA, 32'hFFFFFFFF, 32'h1A5);
        fork
            peer.recv(d, s, 9);
            apb(1'b1, UDBC_OFF_DATA, 32'h14B);
        join
        chk({23'h0, d}, 32'h1FF, 32'h14B);
        apb(1'b1, UDBC_OFF_CTL, C_RUN & ~C_RE);
        peer.send(9'h033, 8, 1'b1);
        rd(UDBC_OFF_FLAGS, 32'h20, 32'h0);
        apb(1'b1, UDBC_OFF_CTL, C_RUN | C_WAKE | C_SIL);
        peer.send(9'h012, 8, 1'b1);
        rd(UDBC_OFF_FLAGS, 32'h20, 32'h0);
        peer.send(9'h092, 8, 1'b1);
        rd(UDBC_OFF_FLAGS, 32'h20, 32'h20);
        rd(UDBC_OFF_DATA, 32'hFF, 32'h92);
        final_report();
    end
endmodule

/* test/udbc_peer.sv */
// Remote serial peer: drives the receive line and captures the transmit line.
// Assumes one bit lasts BIT pclk cycles, matching the baud register setting.
`timescale 1ns/1ps
module udbc_peer #(
    parameter int BIT = 24
) (
    // Clock
    input  wire logic pclk,
    // Serial line
    output logic      rxd,
    input  wire logic txd
);
    initial rxd = 1'b1;

    // Start, nb bits LSB first, stop, then one idle bit
    task automatic send(input logic [8:0] d, input int nb, input logic stop);
        rxd <= 1'b0;
        repeat (BIT) @(posedge pclk);
        for (int i = 0; i < nb; i++) begin
            rxd <= d[i];
            repeat (BIT) @(posedge pclk);
        end
        rxd <= stop;
        repeat (BIT) @(posedge pclk);
        rxd <= 1'b1;
        repeat (BIT) @(posedge pclk);
    endtask

    // Mid-bit sampling, so a wrong divider drifts into the wrong bit
    task automatic recv(output logic [8:0] d, output logic stop, input int nb);
        d = '0;
        while (txd !== 1'b0) @(posedge pclk);
        repeat (BIT / 2) @(posedge pclk);
        for (int i = 0; i < nb; i++) begin
            repeat (BIT) @(posedge pclk);
            d[i] = txd;
        end
        repeat (BIT) @(posedge pclk);
        stop = txd;
    endtask
endmodule
